// *** src/ircp_map.vh ***
`ifndef IRCP_MAP_VH
`define IRCP_MAP_VH
// apb register byte offsets
`define IRCP_REG_CTRL 12'h000
`define IRCP_REG_STAT 12'h004
`define IRCP_REG_INQ 12'h008
`define IRCP_REG_OUTQ 12'h00C
`define IRCP_REG_ERRQ 12'h010
`define IRCP_REG_ESR 12'h014
`define IRCP_REG_ADDR 12'h018
// ctrl register fields
`define IRCP_CTRL_DONE 0
`define IRCP_CTRL_CLRESR 1
`define IRCP_CTRL_LOCAL 2
`define IRCP_CTRL_SRQ 3
// status byte bit for message available
`define IRCP_STB_MAV 4
// event status error bits 2..5
`define IRCP_ESR_LO 2
`define IRCP_ESR_HI 5
// sizes
`define IRCP_INQ_DEPTH 11'h400
`define IRCP_INQ_AW 10
`define IRCP_OUTQ_DEPTH 9'h112
`define IRCP_OUTQ_AW 9
`define IRCP_ERRQ_DEPTH 5'h1E
`define IRCP_ERR_OVF 16'hFEA2
`define IRCP_DEF_ADDR 5'h18
// characters
`define IRCP_CH_LF 8'h0A
`define IRCP_CH_SP 8'h20
`define IRCP_CH_SEMI 8'h3B
// bus commands on dio with atn
`define IRCP_CMD_GTL 7'h01
`define IRCP_CMD_SDC 7'h04
`define IRCP_CMD_GET 7'h08
`define IRCP_CMD_LLO 7'h11
`define IRCP_CMD_DCL 7'h14
`define IRCP_CMD_SPE 7'h18
`define IRCP_CMD_SPD 7'h19
`define IRCP_CMD_UNL 7'h3F
`define IRCP_CMD_UNT 7'h5F
`define IRCP_LAG_BASE 2'h1
`define IRCP_TAG_BASE 2'h2
`endif

// *** src/ircp_sync.v ***
`timescale 1ns/1ps
// two-stage synchroniser per bit
module ircp_sync #(
    parameter W = 1
) (
    clk,
    srst,
    din,
    dout
);
input wire clk;
input wire srst;
input wire [W-1:0] din;
output reg [W-1:0] dout;
reg [W-1:0] meta;

// first stage read only by second; reset to the idle high of pulled-up lines
always @(posedge clk) begin
    if (srst) begin
        meta <= {W{1'b1}};
        dout <= {W{1'b1}};
    end else begin
        meta <= din;
        dout <= meta;
    end
end
endmodule

// *** src/ircp_normalize.v ***
`timescale 1ns/1ps
`include "ircp_map.vh"
// character normaliser: case fold, control except lf to space, space collapse
module ircp_normalize (
    clk,
    srst,
    inValid,
    inByte,
    outValid,
    outByte
);
input wire clk;
input wire srst;
input wire inValid;
input wire [7:0] inByte;
output reg outValid;
output reg [7:0] outByte;
reg lastSpace;
reg [7:0] mapped;

always @* begin
    mapped = inByte;
    if (inByte != `IRCP_CH_LF && inByte < `IRCP_CH_SP)
        mapped = `IRCP_CH_SP;
    else if (inByte >= 8'h61 && inByte <= 8'h7A)
        mapped = inByte - 8'h20;
end

always @(posedge clk) begin
    if (srst) begin
        outValid <= 1'b0;
        outByte <= 8'h00;
        lastSpace <= 1'b0;
    end else begin
        outValid <= 1'b0;
        if (inValid) begin
            if (!(mapped == `IRCP_CH_SP && lastSpace)) begin
                outValid <= 1'b1;
                outByte <= mapped;
            end
            lastSpace <= (mapped == `IRCP_CH_SP);
        end
    end
end
endmodule

// *** src/ircp_port.v ***
`timescale 1ns/1ps
`include "ircp_map.vh"
////////////////////////////////////////////////////////////////////////////////
module ircp_port (
    clk,
    srst,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    dioIn,
    dioOut,
    dioOe,
    dav_nIn,
    dav_nOut,
    dav_nOe,
    nrfd_nIn,
    nrfd_nOe,
    ndac_nIn,
    ndac_nOe,
    eoi_nIn,
    eoi_nOut,
    eoi_nOe,
    atn_nIn,
    ifc_nIn,
    ren_nIn,
    srq_nOe,
    panelAddr,
    panelAddrLoad,
    localKey,
    remoteState,
    remote_lockout_state,
    devClear,
    cmdReady
);
input wire clk;
input wire srst;
input wire psel;
input wire penable;
input wire pwrite;
input wire [11:0] paddr;
input wire [31:0] pwdata;
output reg [31:0] prdata;
output wire pready;
output wire pslverr;
input wire [7:0] dioIn;
output reg [7:0] dioOut;
output wire dioOe;
input wire dav_nIn;
output wire dav_nOut;
output wire dav_nOe;
input wire nrfd_nIn;
output wire nrfd_nOe;
input wire ndac_nIn;
output wire ndac_nOe;
input wire eoi_nIn;
output wire eoi_nOut;
output wire eoi_nOe;
input wire atn_nIn;
input wire ifc_nIn;
input wire ren_nIn;
output wire srq_nOe;
input wire [4:0] panelAddr;
input wire panelAddrLoad;
input wire localKey;
output reg remoteState;
output reg remote_lockout_state;
output reg devClear;
output wire cmdReady;

// acceptor states
localparam AIDL = 3'b001;
localparam ACPT = 3'b010;
localparam AWAT = 3'b100;
// source states
localparam SIDL = 3'b001;
localparam SDAV = 3'b010;
localparam SWAT = 3'b100;

wire [7:0] dio;
wire dav, nrfd, ndac, eoi, atn, ifc, ren;
reg [2:0] aState, sState;
reg [4:0] myAddr;
reg listen, talk, spoll, srqReq;
reg [7:0] inMem [0:1023];
reg [`IRCP_INQ_AW-1:0] inWr, inRd;
reg [10:0] inCnt, lfCnt;
reg [7:0] outMem [0:511];
reg [`IRCP_OUTQ_AW-1:0] outWr, outRd;
reg [8:0] outCnt;
reg [15:0] errMem [0:31];
reg [4:0] errWr, errRd;
reg [5:0] errCnt;
reg [3:0] esrBits;
reg [7:0] rxByte;
reg rxEoi, rxStb, normEoi, eoiSeen;
wire normValid;
wire [7:0] normByte;
wire apbWr, apbRd;
wire [6:0] cmd;
wire inFull, outEmpty, errPush, outPush, errPop, inPop, cmdDone;
wire [7:0] stb;

// bus lines cross into clk domain
ircp_sync #(.W(15)) uSync (
    .clk(clk),
    .srst(srst),
    .din({dioIn, dav_nIn, nrfd_nIn, ndac_nIn, eoi_nIn, atn_nIn, ifc_nIn, ren_nIn}),
    .dout({dio, dav, nrfd, ndac, eoi, atn, ifc, ren})
);

assign cmd = ~dio[6:0];
assign inFull = (inCnt == `IRCP_INQ_DEPTH);
assign outEmpty = (outCnt == 9'h000);
assign stb = {1'b0, srqReq, 1'b0, ~outEmpty, 4'h0};

////////////////////////////////////////////////////////////////////////////////
// apb slave, zero wait
assign pready = 1'b1;
assign pslverr = 1'b0;
assign apbWr = psel & penable & pwrite;
assign apbRd = psel & penable & ~pwrite;
assign inPop = apbRd && paddr == `IRCP_REG_INQ && inCnt != 11'h000;
assign errPop = apbRd && paddr == `IRCP_REG_ERRQ && errCnt != 6'h00;
assign errPush = apbWr && paddr == `IRCP_REG_ERRQ;
assign outPush = apbWr && paddr == `IRCP_REG_OUTQ && outCnt != `IRCP_OUTQ_DEPTH;
assign cmdDone = apbWr && paddr == `IRCP_REG_CTRL && pwdata[`IRCP_CTRL_DONE];
// parse trigger on lf or full
assign cmdReady = (lfCnt != 11'h000) | inFull;

// read data captured in setup phase, stands through access
always @(posedge clk) begin
    if (srst)
        prdata <= 32'h00000000;
    else if (psel && !penable) begin
        case (paddr)
            `IRCP_REG_STAT: prdata <= {16'h0000, 2'b00, errCnt, stb};
            `IRCP_REG_INQ: prdata <= {21'h000000, inCnt == 11'h000, 2'b00, inMem[inRd]};
            `IRCP_REG_ERRQ: prdata <= {15'h0000, errCnt == 6'h00, errMem[errRd]};
            `IRCP_REG_ESR: prdata <= {26'h0000000, esrBits, 2'b00};
            `IRCP_REG_ADDR: prdata <= {22'h000000, remote_lockout_state, remoteState,
                listen, talk, 1'b0, myAddr};
            default: prdata <= 32'h00000000;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// address from panel only
always @(posedge clk) begin
    if (srst)
        myAddr <= `IRCP_DEF_ADDR;
    else if (panelAddrLoad)
        myAddr <= panelAddr;
end

// addressing, remote/local, clear, poll; no parallel poll or controller logic
// no ppoll or controller
always @(posedge clk) begin
    if (srst) begin
        listen <= 1'b0;
        talk <= 1'b0;
        spoll <= 1'b0;
        remoteState <= 1'b0;
        remote_lockout_state <= 1'b0;
        devClear <= 1'b0;
    end else begin
        devClear <= 1'b0;
        if (!ifc) begin
            listen <= 1'b0;
            talk <= 1'b0;
            spoll <= 1'b0;
        end else if (rxStb && !atn) begin
            if (cmd[6:5] == `IRCP_LAG_BASE && cmd[4:0] == myAddr) begin
                listen <= 1'b1;
                talk <= 1'b0;
            end else if (cmd == `IRCP_CMD_UNL)
                listen <= 1'b0;
            if (cmd[6:5] == `IRCP_TAG_BASE) begin
                talk <= (cmd[4:0] == myAddr);
                if (cmd[4:0] == myAddr)
                    listen <= 1'b0;
            end else if (cmd == `IRCP_CMD_UNT)
                talk <= 1'b0;
            if (cmd == `IRCP_CMD_SPE)
                spoll <= 1'b1;
            if (cmd == `IRCP_CMD_SPD)
                spoll <= 1'b0;
            if (cmd == `IRCP_CMD_GTL && listen) begin
                remoteState <= 1'b0;
                remote_lockout_state <= 1'b0;
            end
            if (cmd == `IRCP_CMD_LLO) begin
                remote_lockout_state <= 1'b1;
                remoteState <= 1'b1;
            end
            if (cmd == `IRCP_CMD_DCL || (cmd == `IRCP_CMD_SDC && listen))
                devClear <= 1'b1;
        end else if (rxStb && listen && !ren)
            remoteState <= 1'b1;
        else if (localKey && !remote_lockout_state)
            remoteState <= 1'b0;
        // ren line high: remote enable false, force local
        if (ren) begin
            remoteState <= 1'b0;
            remote_lockout_state <= 1'b0;
        end
    end
end

always @(posedge clk) begin
    if (srst)
        srqReq <= 1'b0;
    else if (apbWr && paddr == `IRCP_REG_CTRL)
        srqReq <= pwdata[`IRCP_CTRL_SRQ];
end
assign srq_nOe = srqReq;

////////////////////////////////////////////////////////////////////////////////
// acceptor handshake
assign nrfd_nOe = (listen | ~atn) & (aState != AIDL || inFull);
assign ndac_nOe = (listen | ~atn) & (aState != AWAT);
always @(posedge clk) begin
    if (srst) begin
        aState <= AIDL;
        rxStb <= 1'b0;
        rxByte <= 8'h00;
        rxEoi <= 1'b0;
    end else begin
        rxStb <= 1'b0;
        case (aState)
            AIDL: if (!dav && (listen || !atn) && !inFull) begin
                rxByte <= ~dio;
                rxEoi <= ~eoi;
                rxStb <= 1'b1;
                aState <= ACPT;
            end
            ACPT: aState <= AWAT;
            AWAT: if (dav)
                aState <= AIDL;
            default: aState <= AIDL;
        endcase
    end
end

assign dioOe = talk & (sState != SIDL);
assign dav_nOe = talk & (sState == SDAV);
assign dav_nOut = 1'b0;
assign eoi_nOe = dav_nOe & ~spoll & (outCnt == 9'h001);
assign eoi_nOut = 1'b0;
always @(posedge clk) begin
    if (srst) begin
        sState <= SIDL;
        dioOut <= 8'hFF;
    end else begin
        case (sState)
            SIDL: if (talk && atn && nrfd && (spoll || !outEmpty)) begin
                dioOut <= spoll ? ~stb : ~outMem[outRd];
                sState <= SDAV;
            end
            SDAV: if (ndac)
                sState <= SWAT;
            SWAT: if (!ndac || !talk)
                sState <= SIDL;
            default: sState <= SIDL;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// normaliser
ircp_normalize uNorm (
    .clk(clk),
    .srst(srst),
    .inValid(rxStb & atn & listen),
    .inByte(rxByte),
    .outValid(normValid),
    .outByte(normByte)
);

// eoi lf lands one cycle after its own byte
always @(posedge clk) begin
    if (srst) begin
        eoiSeen <= 1'b0;
        normEoi <= 1'b0;
    end else begin
        eoiSeen <= rxStb & atn & listen & rxEoi & (rxByte != `IRCP_CH_LF);
        normEoi <= eoiSeen;
    end
end

always @(posedge clk) begin
    if (srst || devClear) begin
        inWr <= {`IRCP_INQ_AW{1'b0}};
        inRd <= {`IRCP_INQ_AW{1'b0}};
        inCnt <= 11'h000;
        lfCnt <= 11'h000;
    end else begin
        if ((normValid || normEoi) && !inFull) begin
            inMem[inWr] <= normValid ? normByte : `IRCP_CH_LF;
            inWr <= inWr + 1'b1;
        end
        if (inPop)
            inRd <= inRd + 1'b1;
        inCnt <= inCnt + {10'h000, (normValid | normEoi) & ~inFull} - {10'h000, inPop};
        // only lf, received or inserted after eoi, delimits commands for parser
        lfCnt <= lfCnt + {10'h000, ~inFull & ((normValid & normByte == `IRCP_CH_LF)
            | (normEoi & ~normValid))} - {10'h000, cmdDone & lfCnt != 11'h000};
    end
end

// output queue, cleared by new command
always @(posedge clk) begin
    if (srst || devClear || (rxStb && atn && listen && lfCnt == 11'h000
        && inCnt == 11'h000)) begin
        outWr <= {`IRCP_OUTQ_AW{1'b0}};
        outRd <= {`IRCP_OUTQ_AW{1'b0}};
        outCnt <= 9'h000;
    end else begin
        if (outPush) begin
            outMem[outWr] <= pwdata[7:0];
            outWr <= outWr + 1'b1;
        end
        if (sState == SWAT && !ndac && !spoll) begin
            outRd <= outRd + 1'b1;
        end
        outCnt <= outCnt + {8'h00, outPush} - {8'h00, sState == SWAT & ~ndac & ~spoll};
    end
end

// error fifo with overflow entry, pop oldest
always @(posedge clk) begin
    if (srst) begin
        errWr <= 5'h00;
        errRd <= 5'h00;
        errCnt <= 6'h00;
    end else begin
        if (errPush && errCnt < {1'b0, `IRCP_ERRQ_DEPTH}) begin
            errMem[errWr] <= (errCnt == {1'b0, `IRCP_ERRQ_DEPTH} - 6'h01)
                ? `IRCP_ERR_OVF : pwdata[15:0];
            errWr <= (errWr == `IRCP_ERRQ_DEPTH - 5'h01) ? 5'h00 : errWr + 5'h01;
        end
        if (errPop)
            errRd <= (errRd == `IRCP_ERRQ_DEPTH - 5'h01) ? 5'h00 : errRd + 5'h01;
        errCnt <= errCnt + {5'h00, errPush & (errCnt < {1'b0, `IRCP_ERRQ_DEPTH})}
            - {5'h00, errPop};
    end
end

// esr error bits, set wins over clear
always @(posedge clk) begin
    if (srst)
        esrBits <= 4'h0;
    else if (errPush)
        esrBits <= esrBits | pwdata[16+`IRCP_ESR_HI:16+`IRCP_ESR_LO];
    else if (apbWr && paddr == `IRCP_REG_CTRL && pwdata[`IRCP_CTRL_CLRESR])
        esrBits <= 4'h0;
end
endmodule

// *** test/ircp_monitor.sv ***
`timescale 1ns/1ps
`include "ircp_map.vh"
// pin-level checks on the remote port
module ircp_monitor (
    input wire clk,
    input wire srst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [7:0] dioOut,
    input wire dioOe,
    input wire dav_nIn,
    input wire dav_nOe,
    input wire nrfd_nIn,
    input wire ndac_nIn,
    input wire ndac_nOe,
    input wire eoi_nOe,
    input wire atn_nIn,
    input wire localKey,
    input wire remoteState,
    input wire remote_lockout_state,
    input wire devClear,
    input wire srq_nOe
);
default clocking cb @(posedge clk); endclocking
default disable iff (srst);
////////////////////////////////////////
// ctrl writes that set or drop the request
sequence s_srqOn; psel && penable && pwrite && paddr == `IRCP_REG_CTRL && pwdata[3]; endsequence
sequence s_srqOff; psel && penable && pwrite && paddr == `IRCP_REG_CTRL && !pwdata[3]; endsequence
property p_srqOn; s_srqOn |-> ##[1:3] srq_nOe; endproperty
a_srqOn: assert property (p_srqOn) else $error("srq not raised");
property p_srqOff; s_srqOff |-> ##[1:3] !srq_nOe; endproperty
a_srqOff: assert property (p_srqOff) else $error("srq not dropped");
property p_clrPulse; devClear |=> !devClear; endproperty
a_clrPulse: assert property (p_clrPulse) else $error("clear pulse too long");
property p_noPoll; !atn_nIn [*6] |-> !dioOe; endproperty
a_noPoll: assert property (p_noPoll) else $error("dio driven under atn");
property p_davRfd; $rose(dav_nOe) |-> nrfd_nIn && $past(nrfd_nIn); endproperty
a_davRfd: assert property (p_davRfd) else $error("dav before ready");
property p_dioHold; dav_nOe && $past(dav_nOe) |-> $stable(dioOut) && dioOe; endproperty
a_dioHold: assert property (p_dioHold) else $error("data moved under dav");
property p_davAck; $fell(dav_nOe) |-> $past(ndac_nIn); endproperty
a_davAck: assert property (p_davAck) else $error("dav dropped early");
property p_ndacRel; $fell(ndac_nOe) && !atn_nIn |-> !dav_nIn; endproperty
a_ndacRel: assert property (p_ndacRel) else $error("ndac released idle");
property p_eoiLf; eoi_nOe && dav_nOe |-> dioOut == 8'hF5; endproperty
a_eoiLf: assert property (p_eoiLf) else $error("eoi not on lf");
property p_keyLocal; remoteState && !remote_lockout_state && localKey |-> ##[1:4] !remoteState; endproperty
a_keyLocal: assert property (p_keyLocal) else $error("key ignored");
property p_keyLocked; remoteState && remote_lockout_state && localKey |=> remoteState; endproperty
a_keyLocked: assert property (p_keyLocked) else $error("lockout broken");
endmodule
bind ircp_port ircp_monitor u_mon (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .dioOut(dioOut), .dioOe(dioOe), .dav_nIn(dav_nIn),
    .dav_nOe(dav_nOe), .nrfd_nIn(nrfd_nIn), .ndac_nIn(ndac_nIn), .ndac_nOe(ndac_nOe),
    .eoi_nOe(eoi_nOe), .atn_nIn(atn_nIn), .localKey(localKey), .remoteState(remoteState),
    .remote_lockout_state(remote_lockout_state), .devClear(devClear), .srq_nOe(srq_nOe)
);

// *** test/ircp_ctl_model.sv ***
`timescale 1ns/1ps
// bus controller with open-collector lines
module ircp_ctl_model (
    input wire clk,
    input wire [7:0] dioOut,
    input wire dioOe,
    input wire dav_nOut,
    input wire dav_nOe,
    input wire nrfd_nOe,
    input wire ndac_nOe,
    input wire eoi_nOut,
    input wire eoi_nOe,
    output wire [7:0] dioIn,
    output wire dav_nIn,
    output wire nrfd_nIn,
    output wire ndac_nIn,
    output wire eoi_nIn,
    output reg atn_nIn,
    output reg gotStb,
    output reg [8:0] gotWord
);
reg [7:0] dat = 8'hFF;
reg cDav = 1'h1;
reg cEoi = 1'h1;
reg cRfd = 1'h0;
reg cDac = 1'h0;
initial begin
    atn_nIn = 1'h1;
    gotStb = 1'h0;
    gotWord = 9'h0;
end
// released lines rise through the pull-ups
assign dioIn = (dioOe ? dioOut : 8'hFF) & dat;
assign dav_nIn = (dav_nOe ? dav_nOut : 1'h1) & cDav;
assign eoi_nIn = (eoi_nOe ? eoi_nOut : 1'h1) & cEoi;
assign nrfd_nIn = !(nrfd_nOe || cRfd);
assign ndac_nIn = !(ndac_nOe || cDac);
// byte out, eoi may end a message
task send(input [7:0] b, input a, input e);
    begin
        @(posedge clk);
        atn_nIn <= !a;
        cRfd <= 1'h0;
        cDac <= 1'h0;
        dat <= ~b;
        cEoi <= !e;
        repeat (4) @(posedge clk);
        while (!nrfd_nIn) @(posedge clk);
        cDav <= 1'h0;
        @(posedge clk);
        while (!ndac_nIn) @(posedge clk);
        cDav <= 1'h1;
        dat <= 8'hFF;
        cEoi <= 1'h1;
    end
endtask
// acceptor side while the port talks
task recv;
    begin
        @(posedge clk);
        atn_nIn <= 1'h1;
        cDac <= 1'h1;
        cRfd <= 1'h0;
        @(posedge clk);
        while (dav_nIn) @(posedge clk);
        gotWord <= {!eoi_nIn, ~dioIn};
        cRfd <= 1'h1;
        cDac <= 1'h0;
        @(posedge clk);
        while (!dav_nIn) @(posedge clk);
        cDac <= 1'h1;
        cRfd <= 1'h0;
        gotStb <= 1'h1;
        @(posedge clk);
        gotStb <= 1'h0;
    end
endtask
endmodule

// *** test/ircp_port_tb.sv ***
`timescale 1ns/1ps
`include "ircp_map.vh"
module ircp_port_tb;
reg clk, srst, psel, penable, pwrite, panelAddrLoad, localKey, sawClr;
reg [11:0] paddr;
reg [31:0] pwdata, seed;
reg [4:0] panelAddr;
reg [63:0] e;
reg [63:0] expq [$];
reg [15:0] codes [0:29];
integer miscompares, tests_run, cyc, i;
wire [31:0] prdata;
wire [7:0] dioIn, dioOut;
wire [8:0] gotWord;
wire pready, pslverr, dioOe, dav_nIn, dav_nOut, dav_nOe, nrfd_nIn, nrfd_nOe, ndac_nIn;
wire ndac_nOe, eoi_nIn, eoi_nOut, eoi_nOe, atn_nIn, srq_nOe, remoteState, gotStb;
wire remote_lockout_state, devClear, cmdReady;
wire ifc_nIn = 1'h1;
wire ren_nIn = 1'h0;
localparam [7:0] LSN = 8'h38;
localparam [55:0] MSG = 56'h3105203B320A33;
localparam [55:0] NRM = 56'h31203B320A330A;
ircp_port DUT (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dioIn(dioIn), .dioOut(dioOut), .dioOe(dioOe), .dav_nIn(dav_nIn), .dav_nOut(dav_nOut),
    .dav_nOe(dav_nOe), .nrfd_nIn(nrfd_nIn), .nrfd_nOe(nrfd_nOe), .ndac_nIn(ndac_nIn),
    .ndac_nOe(ndac_nOe), .eoi_nIn(eoi_nIn), .eoi_nOut(eoi_nOut), .eoi_nOe(eoi_nOe),
    .atn_nIn(atn_nIn), .ifc_nIn(ifc_nIn), .ren_nIn(ren_nIn), .srq_nOe(srq_nOe),
    .panelAddr(panelAddr), .panelAddrLoad(panelAddrLoad), .localKey(localKey),
    .remoteState(remoteState), .remote_lockout_state(remote_lockout_state),
    .devClear(devClear), .cmdReady(cmdReady)
);
ircp_ctl_model ctl (
    .clk(clk), .dioOut(dioOut), .dioOe(dioOe), .dav_nOut(dav_nOut), .dav_nOe(dav_nOe),
    .nrfd_nOe(nrfd_nOe), .ndac_nOe(ndac_nOe), .eoi_nOut(eoi_nOut), .eoi_nOe(eoi_nOe),
    .dioIn(dioIn), .dav_nIn(dav_nIn), .nrfd_nIn(nrfd_nIn), .ndac_nIn(ndac_nIn),
    .eoi_nIn(eoi_nIn), .atn_nIn(atn_nIn), .gotStb(gotStb), .gotWord(gotWord)
);
initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
end
////////////////////////////////////////
task check(input [31:0] seen, input [31:0] exp);
    begin
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
        end
    end
endtask
task end_sim;
    begin
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    end
endtask
task apb(input w, input [11:0] a, input [31:0] d, input [31:0] m);
    begin
        if (!w) expq.push_back({m, d});
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        psel <= 1'h0;
        penable <= 1'h0;
    end
endtask
task key;
    begin
        repeat (8) @(posedge clk);
        localKey <= 1'h1;
        @(posedge clk);
        localKey <= 1'h0;
        repeat (8) @(posedge clk);
    end
endtask
function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    end
endfunction
// oldest note against each read or received byte
always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
        e = expq.pop_front();
        check(prdata & e[63:32], e[31:0] & e[63:32]);
    end
    if (gotStb === 1'h1) begin
        e = expq.pop_front();
        check({23'h0, gotWord}, e[31:0]);
    end
    if (devClear === 1'h1) sawClr = 1'h1;
    cyc = cyc + 1;
    if (cyc == 50000) begin
        miscompares = miscompares + 1;
        end_sim;
    end
end
////////////////////////////////////////
// main sequence
initial begin
    {srst, psel, penable, pwrite, paddr, pwdata} = {1'h1, 47'h0};
    {panelAddr, panelAddrLoad, localKey, sawClr} = 8'h0;
    {miscompares, tests_run, cyc} = 96'h0;
    seed = 32'h873AF263;
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    apb(0, `IRCP_REG_ADDR, 32'h18, 32'h3FF);
    ctl.send(LSN, 1, 0);
    for (i = 0; i < 7; i = i + 1) ctl.send(MSG[55 - 8 * i -: 8], 0, i == 6);
    while (cmdReady !== 1'h1) @(posedge clk);
    check({31'h0, remoteState}, 32'h1);
    for (i = 0; i < 7; i = i + 1) apb(0, `IRCP_REG_INQ, NRM[55 - 8 * i -: 8], 32'h4FF);
    apb(0, `IRCP_REG_INQ, 32'h400, 32'h400);
    apb(0, `IRCP_REG_ADDR, 32'h198, 32'h3DF);
    repeat (2) apb(1, `IRCP_REG_CTRL, 32'h1, 0);
    @(posedge clk);
    check({31'h0, cmdReady}, 32'h0);
    ctl.send(8'h11, 1, 0);
    key;
    check({30'h0, remote_lockout_state, remoteState}, 32'h3);
    ctl.send(8'h01, 1, 0);
    key;
    check({30'h0, remote_lockout_state, remoteState}, 32'h0);
    ctl.send(8'h39, 0, 0);
    key;
    check({31'h0, remoteState}, 32'h0);
    srst <= 1'h1;
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    apb(0, `IRCP_REG_INQ, 32'h400, 32'h400);
    ctl.send(LSN, 1, 0);
    repeat (1023) ctl.send(8'h37, 0, 0);
    key;
    check({31'h0, cmdReady}, 32'h0);
    ctl.send(8'h37, 0, 0);
    key;
    check({31'h0, cmdReady}, 32'h1);
    repeat (1024) apb(0, `IRCP_REG_INQ, 32'h37, 32'h4FF);
    apb(1, `IRCP_REG_CTRL, 32'h1, 0);
    ctl.send(8'h14, 1, 0);
    ctl.send(8'h08, 1, 0);
    check({31'h0, sawClr}, 32'h1);
    apb(0, `IRCP_REG_STAT, 32'h0, 32'h3F00);
    apb(1, `IRCP_REG_OUTQ, 32'h35, 0);
    apb(1, `IRCP_REG_OUTQ, 32'h0A, 0);
    apb(0, `IRCP_REG_STAT, 32'h10, 32'h10);
    ctl.send(8'h58, 1, 0);
    expq.push_back(64'h35);
    ctl.recv;
    expq.push_back(64'h10A);
    ctl.recv;
    apb(0, `IRCP_REG_ADDR, 32'h40, 32'hC0);
    apb(0, `IRCP_REG_STAT, 32'h0, 32'h10);
    ctl.send(LSN, 1, 0);
    apb(0, `IRCP_REG_ADDR, 32'h80, 32'hC0);
    apb(1, `IRCP_REG_OUTQ, 32'h35, 0);
    apb(0, `IRCP_REG_STAT, 32'h10, 32'h10);
    ctl.send(8'h31, 0, 0);
    key;
    apb(0, `IRCP_REG_STAT, 32'h0, 32'h10);
    apb(1, `IRCP_REG_CTRL, 32'h8, 0);
    apb(0, `IRCP_REG_STAT, 32'h40, 32'h40);
    apb(1, `IRCP_REG_CTRL, 32'h0, 0);
    for (i = 0; i < 31; i = i + 1) begin
        seed = xs(seed);
        if (i < 30) codes[i] = (i == 29) ? 16'hFEA2 : seed[15:0];
        apb(1, `IRCP_REG_ERRQ, {10'h0, (i == 0) ? 4'hF : 4'h0, 2'h0, seed[15:0]}, 0);
    end
    apb(0, `IRCP_REG_ESR, 32'h3C, 32'h3C);
    apb(0, `IRCP_REG_STAT, 32'h1E00, 32'h3F00);
    for (i = 0; i < 30; i = i + 1) apb(0, `IRCP_REG_ERRQ, codes[i], 32'h1FFFF);
    apb(0, `IRCP_REG_ERRQ, 32'h10000, 32'h10000);
    apb(1, `IRCP_REG_CTRL, 32'h2, 0);
    apb(0, `IRCP_REG_ESR, 32'h0, 32'h3C);
    apb(0, 12'hFFC, 32'h0, 32'hFFFFFFFF);
    panelAddr <= 5'h05;
    panelAddrLoad <= 1'h1;
    @(posedge clk);
    panelAddrLoad <= 1'h0;
    apb(0, `IRCP_REG_ADDR, 32'h05, 32'h1F);
    @(posedge clk);
    end_sim;
end
endmodule
